// *** dv/camera_video_output_framer_tb.sv ***
module camera_video_output_framer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                clk, nrst, pixClk, frameReady, exposing, pixTake, integrateActive, rxStb;
    cvf_pkg::cvf_mode_t  modeSel;
    logic [15:0]         aoiPixels, aoiLines;
    cvf_pkg::cvf_pixel_t pixIn;
    cvf_pkg::cvf_link_t  vidOut;
    logic [23:0]         rxData;
    logic [23:0]         expQ[$];
    int                  fail_count = 0, compares = 0, got = 0;
    cvf_framer DUT (.clk, .nrst, .pixClk, .modeSel, .frameReady, .exposing, .aoiPixels, .aoiLines, .pixIn,
        .pixTake, .vidOut, .integrateActive);
    cvf_grabber_model GRB (.pixClk, .vidOut, .rxStb, .rxData);
    initial begin clk = 0; forever #50 clk = ~clk; end
    initial begin pixClk = 0; #37; forever #400 pixClk = ~pixClk; end
    function automatic logic [23:0] expWord(cvf_pkg::cvf_pixel_t p, cvf_pkg::cvf_mode_t m);
        case (m)
            cvf_pkg::CVF_MONO10: return {14'h0000, p.mono[11:2]};
            cvf_pkg::CVF_MONO8:  return {16'h0000, p.mono[11:4]};
            cvf_pkg::CVF_RGB24:  return {p.blue, p.green, p.red};
            default:             return {12'h000, p.mono};
        endcase
    endfunction
    task automatic check(string what, logic [23:0] exp, logic [23:0] act);
        compares++;
        if (act !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, act);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // source hands the next pixel once the current one is launched
    always @(posedge clk) if (pixTake === 1'b1) begin
        expQ.push_back(expWord(pixIn, modeSel));
        #5 pixIn = 36'({$urandom(), $urandom()});
    end
    always @(posedge rxStb) begin
        got++;
        check("pixel", expQ.size() > 0 ? expQ.pop_front() : ~rxData, rxData);
    end
    task automatic run_frame(cvf_pkg::cvf_mode_t m, int w, int l, bit twice);
        int n;
        @(posedge clk); #5;
        modeSel = m; aoiPixels = 16'(w); aoiLines = 16'(l); got = 0; frameReady = 1;
        @(posedge clk); #5 frameReady = 0;
        // second request lands mid-frame and must stay pending
        if (twice) begin repeat (40) @(posedge clk); #5 frameReady = 1; @(posedge clk); #5 frameReady = 0; end
        for (n = 0; n < 30000 && !(got == w * l * (twice + 1) && vidOut.frameValid === 1'b0); n++) @(posedge clk);
        #5;
        if (n == 30000) begin fail_count++; finish_test(); end
        check("pixel count", 24'(w * l * (twice + 1)), 24'(got));
    endtask
    initial begin
        nrst = 0; frameReady = 0; exposing = 0; modeSel = cvf_pkg::CVF_MONO12;
        aoiPixels = 16'h0004; aoiLines = 16'h0003; pixIn = '0;
        void'($urandom(66));
        repeat (6) @(posedge clk); #5 nrst = 1;
        run_frame(cvf_pkg::CVF_MONO12, 1, 1, 0);
        for (int i = 0; i < 8; i++) begin
            exposing = i[0];
            run_frame(cvf_pkg::cvf_mode_t'(i[1:0]), 1 + $urandom_range(5), 1 + $urandom_range(2), i == 5);
            check("integrate", 24'(exposing), 24'(integrateActive));
        end
        frameReady = 1; @(posedge clk); #5 frameReady = 0;
        repeat (100) @(posedge clk); #5 nrst = 0; #1;
        check("reset outputs", 24'h000000, 24'({vidOut[26:24], integrateActive}));
        @(posedge clk); #5 nrst = 1; expQ.delete();
        run_frame(cvf_pkg::CVF_RGB24, 3, 2, 0);
        finish_test();
    end
endmodule

// *** dv/cvf_framer_asserts.sv ***
module cvf_framer_asserts #(
    parameter int CNT_W = 16
) (
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic                pixClk,
    input wire cvf_pkg::cvf_mode_t  modeSel,
    input wire logic                frameReady,
    input wire logic                exposing,
    input wire logic [CNT_W-1:0]    aoiPixels,
    input wire logic [CNT_W-1:0]    aoiLines,
    input wire cvf_pkg::cvf_pixel_t pixIn,
    input wire logic                pixTake,
    input wire cvf_pkg::cvf_link_t  vidOut,
    input wire logic                integrateActive
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_quiet_gap;
        !pixTake [*5];
    endsequence
    a_idle_low: assert property (!vidOut.frameValid |-> !vidOut.lineValid)
        else $error("line valid outside frame");
    a_frame_lead: assert property ($rose(vidOut.frameValid) |-> !vidOut.lineValid [*8])
        else $error("line started with frame valid");
    a_line_start: assert property ($rose(vidOut.lineValid) |-> pixTake)
        else $error("line valid rose without a pixel");
    a_take_inline: assert property (pixTake |-> vidOut.lineValid && vidOut.frameValid)
        else $error("pixel launched outside a line");
    a_mono12_data: assert property (pixTake && modeSel == cvf_pkg::CVF_MONO12 |-> vidOut.data == {12'h000, $past(pixIn.mono)})
        else $error("full depth word wrong");
    a_mono10_data: assert property (pixTake && modeSel == cvf_pkg::CVF_MONO10 |-> vidOut.data == {14'h0000, $past(pixIn.mono[11:2])})
        else $error("ten bit word wrong");
    a_mono8_data: assert property (pixTake && modeSel == cvf_pkg::CVF_MONO8 |-> vidOut.data == {16'h0000, $past(pixIn.mono[11:4])})
        else $error("eight bit word wrong");
    a_rgb_data: assert property (pixTake && modeSel == cvf_pkg::CVF_RGB24 |-> vidOut.data == {$past(pixIn.blue), $past(pixIn.green), $past(pixIn.red)})
        else $error("colour word wrong");
    a_pix_spacing: assert property (pixTake |=> s_quiet_gap)
        else $error("two pixels inside one pixel clock");
    a_line_end: assert property ($fell(vidOut.lineValid) |-> vidOut.frameValid)
        else $error("line closed together with frame");
    a_frame_end: assert property ($fell(vidOut.frameValid) |-> !$past(vidOut.lineValid))
        else $error("frame closed inside a line");
    a_exp_rise: assert property ($rose(exposing) |=> integrateActive)
        else $error("integrate active late");
    a_exp_fall: assert property ($fell(exposing) |=> !integrateActive)
        else $error("integrate active stuck");
    a_reset_low: assert property (disable iff (1'b0) !nrst |-> vidOut == '0 && !integrateActive)
        else $error("outputs live in reset");
    a_dval_mirror: assert property (vidOut.dataValid == vidOut.lineValid)
        else $error("data valid differs from line valid");
    a_data_idle: assert property (!vidOut.lineValid |-> vidOut.data == '0)
        else $error("data not zero outside a line");
endmodule

bind cvf_framer cvf_framer_asserts #(.CNT_W(CNT_W)) u_chk (.clk, .nrst, .pixClk, .modeSel, .frameReady,
    .exposing, .aoiPixels, .aoiLines, .pixIn, .pixTake, .vidOut, .integrateActive);

// *** dv/cvf_grabber_model.sv ***
module cvf_grabber_model (
    input  wire logic                       pixClk,
    input  wire cvf_pkg::cvf_link_t         vidOut,
    output logic                            rxStb,
    output logic [cvf_pkg::LINK_W-1:0]      rxData
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rxStb = 1'b0;
        rxData = '0;
    end
    // falling edge: half a pixel clock after the rise, the word launched three clk edges after that rise is settled
    always @(negedge pixClk) begin
        if (vidOut.frameValid && vidOut.lineValid) begin
            rxData = vidOut.data;
            rxStb = 1'b1;
            #1 rxStb = 1'b0;
        end
    end
endmodule

// *** hw/cvf_framer.sv ***
// Contract
// - both valids low when no image data
// - frame valid rises before first line
// - line start: line valid, first pixel
// - one pixel per cycle, ascending, line valid
// - line valid low after last pixel
// - frame valid low after last line
// - ten or eight bit modes, same framing
// - colour: red, green, blue each cycle
// - launch everything on pixel clock rise; integrate active is registered on every clk instead
// - area of interest shrinks lines, pixels
// - integrate active marks each exposure
// - ten bit mode drops two LSBs
// - eight bit mode drops four LSBs
module cvf_framer #(
    parameter int MAX_PIX   = 1392,
    parameter int MAX_LINES = 1024,
    parameter int CNT_W     = 16
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               pixClk,
    input  wire cvf_pkg::cvf_mode_t modeSel,
    input  wire logic               frameReady,
    input  wire logic               exposing,
    input  wire logic [CNT_W-1:0]   aoiPixels,
    input  wire logic [CNT_W-1:0]   aoiLines,
    input  wire cvf_pkg::cvf_pixel_t pixIn,
    output logic                    pixTake,
    output cvf_pkg::cvf_link_t      vidOut,
    output logic                    integrateActive
);
    typedef enum logic [2:0] {
        S_IDLE,
        S_LEAD,
        S_LINE,
        S_GAP,
        S_TRAIL
    } cvf_state_t;

    localparam logic [CNT_W-1:0] ONE       = CNT_W'(1);
    localparam logic [CNT_W-1:0] LEAD_END  = CNT_W'(cvf_pkg::FRAME_LEAD - 1);
    localparam logic [CNT_W-1:0] GAP_END   = CNT_W'(cvf_pkg::LINE_GAP - 1);
    localparam logic [CNT_W-1:0] TRAIL_END = CNT_W'(cvf_pkg::FRAME_TRAIL - 1);
    localparam logic [CNT_W-1:0] PIX_MAX   = CNT_W'(MAX_PIX);
    localparam logic [CNT_W-1:0] LINE_MAX  = CNT_W'(MAX_LINES);

    // pixel clock sampling; first stage read only by the second
    logic pclkMeta_r;
    logic pclkSync_r;
    logic pclkPrev_r;
    logic pclkMeta_nxt;
    logic pclkSync_nxt;
    logic pclkPrev_nxt;
    logic pclkRise;

    always_comb begin
        pclkMeta_nxt = pixClk;
        pclkSync_nxt = pclkMeta_r;
        pclkPrev_nxt = pclkSync_r;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pclkMeta_r <= 1'b0;
            pclkSync_r <= 1'b0;
            pclkPrev_r <= 1'b0;
        end else begin
            pclkMeta_r <= pclkMeta_nxt;
            pclkSync_r <= pclkSync_nxt;
            pclkPrev_r <= pclkPrev_nxt;
        end
    end

    assign pclkRise = pclkSync_r & ~pclkPrev_r;

    cvf_state_t           state_r, state_nxt;
    logic                 pending_r, pending_nxt;
    logic [CNT_W-1:0]     cnt_r, cnt_nxt;
    logic [CNT_W-1:0]     lineCnt_r, lineCnt_nxt;
    logic [CNT_W-1:0]     width_r, width_nxt;
    logic [CNT_W-1:0]     height_r, height_nxt;
    cvf_pkg::cvf_mode_t   mode_r, mode_nxt;
    cvf_pkg::cvf_link_t   vid_r, vid_nxt;
    logic                 take_r, take_nxt;
    logic                 intAct_r, intAct_nxt;
    logic [cvf_pkg::LINK_W-1:0] word;
    logic                 sendPix;
    logic                 frameStart;
    logic                 lineEnd;
    logic                 frameEnd;
    logic                 stateBad;

    // lane packing per mode
    always_comb begin
        word = '0;
        unique case (mode_r)
            cvf_pkg::CVF_MONO12: begin
                word[cvf_pkg::PIX_W-1:0] = pixIn.mono;
            end
            // reduced depths drop the low converter bits, no rounding
            cvf_pkg::CVF_MONO10: begin
                word[cvf_pkg::MONO10_W-1:0] =
                    pixIn.mono[cvf_pkg::PIX_W-1:cvf_pkg::DROP10];
            end
            cvf_pkg::CVF_MONO8: begin
                word[cvf_pkg::MONO8_W-1:0] =
                    pixIn.mono[cvf_pkg::PIX_W-1:cvf_pkg::DROP8];
            end
            cvf_pkg::CVF_RGB24: begin
                word[cvf_pkg::RED_LSB +: cvf_pkg::COMP_W]   = pixIn.red;
                word[cvf_pkg::GREEN_LSB +: cvf_pkg::COMP_W] = pixIn.green;
                word[cvf_pkg::BLUE_LSB +: cvf_pkg::COMP_W]  = pixIn.blue;
            end
        endcase
    end

    assign frameStart = pclkRise && (state_r == S_IDLE) && pending_r;

    // frame request latch; a pulse meeting the frame start still counts
    always_comb begin
        pending_nxt = pending_r;
        if (frameStart) begin
            pending_nxt = 1'b0;
        end
        if (frameReady) begin
            pending_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pending_r <= 1'b0;
        end else begin
            pending_r <= pending_nxt;
        end
    end

    // settings latched at frame start so a change mid-frame cannot tear it
    always_comb begin
        mode_nxt   = mode_r;
        width_nxt  = width_r;
        height_nxt = height_r;
        if (frameStart) begin
            mode_nxt = modeSel;
            if (aoiPixels == '0 || aoiPixels > PIX_MAX) begin
                width_nxt = PIX_MAX;
            end else begin
                width_nxt = aoiPixels;
            end
            if (aoiLines == '0 || aoiLines > LINE_MAX) begin
                height_nxt = LINE_MAX;
            end else begin
                height_nxt = aoiLines;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_r   <= cvf_pkg::CVF_MONO12;
            width_r  <= '0;
            height_r <= '0;
        end else begin
            mode_r   <= mode_nxt;
            width_r  <= width_nxt;
            height_r <= height_nxt;
        end
    end

    // frame sequencer; every step waits for a pixel clock rise
    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        lineCnt_nxt = lineCnt_r;
        sendPix     = 1'b0;
        lineEnd     = 1'b0;
        frameEnd    = 1'b0;
        stateBad    = 1'b0;
        if (pclkRise) begin
            unique case (state_r)
                S_IDLE: begin
                    if (pending_r) begin
                        cnt_nxt     = '0;
                        lineCnt_nxt = '0;
                        state_nxt   = S_LEAD;
                    end
                end
                S_LEAD: begin
                    cnt_nxt = cnt_r + ONE;
                    if (cnt_r == LEAD_END) begin
                        sendPix   = 1'b1;
                        cnt_nxt   = ONE;
                        state_nxt = S_LINE;
                    end
                end
                // count starts at one: the first pixel leaves with the entry
                S_LINE: begin
                    if (cnt_r == width_r) begin
                        lineEnd     = 1'b1;
                        lineCnt_nxt = lineCnt_r + ONE;
                        cnt_nxt     = '0;
                        state_nxt   = (lineCnt_r + ONE == height_r) ? S_TRAIL : S_GAP;
                    end else begin
                        sendPix = 1'b1;
                        cnt_nxt = cnt_r + ONE;
                    end
                end
                S_GAP: begin
                    cnt_nxt = cnt_r + ONE;
                    if (cnt_r == GAP_END) begin
                        sendPix   = 1'b1;
                        cnt_nxt   = ONE;
                        state_nxt = S_LINE;
                    end
                end
                S_TRAIL: begin
                    cnt_nxt = cnt_r + ONE;
                    if (cnt_r == TRAIL_END) begin
                        frameEnd  = 1'b1;
                        state_nxt = S_IDLE;
                    end
                end
                // unused codes drop the frame rather than emit garbage
                default: begin
                    stateBad    = 1'b1;
                    cnt_nxt     = '0;
                    lineCnt_nxt = '0;
                    state_nxt   = S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r   <= S_IDLE;
            cnt_r     <= '0;
            lineCnt_r <= '0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            lineCnt_r <= lineCnt_nxt;
        end
    end

    // link word and qualifiers; data valid simply mirrors line valid
    always_comb begin
        vid_nxt  = vid_r;
        take_nxt = 1'b0;
        if (frameStart) begin
            vid_nxt.frameValid = 1'b1;
        end
        if (lineEnd) begin
            vid_nxt.lineValid = 1'b0;
            vid_nxt.dataValid = 1'b0;
            vid_nxt.data      = '0;
        end
        if (frameEnd) begin
            vid_nxt.frameValid = 1'b0;
        end
        if (sendPix) begin
            vid_nxt.lineValid = 1'b1;
            vid_nxt.dataValid = 1'b1;
            vid_nxt.data      = word;
            take_nxt          = 1'b1;
        end
        if (stateBad) begin
            vid_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vid_r  <= '0;
            take_r <= 1'b0;
        end else begin
            vid_r  <= vid_nxt;
            take_r <= take_nxt;
        end
    end

    // exposure timing comes from outside; this only registers it
    always_comb begin
        intAct_nxt = exposing;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            intAct_r <= 1'b0;
        end else begin
            intAct_r <= intAct_nxt;
        end
    end

    assign vidOut          = vid_r;
    assign pixTake         = take_r;
    assign integrateActive = intAct_r;
endmodule

// *** hw/cvf_pkg.sv ***
package cvf_pkg;
    localparam int PIX_W       = 12;
    localparam int COMP_W      = 8;
    localparam int LINK_W      = 24;
    localparam int MONO10_W    = 10;
    localparam int MONO8_W     = 8;
    localparam int DROP10      = 2;
    localparam int DROP8       = 4;
    localparam int RED_LSB     = 0;
    localparam int GREEN_LSB   = 8;
    localparam int BLUE_LSB    = 16;

    // time figures are in link pixel-clock periods
    localparam int FRAME_LEAD  = 4;
    localparam int LINE_GAP    = 8;
    localparam int FRAME_TRAIL = 4;

    typedef enum logic [1:0] {
        CVF_MONO12,
        CVF_MONO10,
        CVF_MONO8,
        CVF_RGB24
    } cvf_mode_t;

    typedef struct packed {
        logic [COMP_W-1:0] blue;
        logic [COMP_W-1:0] green;
        logic [COMP_W-1:0] red;
        logic [PIX_W-1:0]  mono;
    } cvf_pixel_t;

    typedef struct packed {
        logic              frameValid;
        logic              lineValid;
        logic              dataValid;
        logic [LINK_W-1:0] data;
    } cvf_link_t;
endpackage
